// ==== inc/poft_defines.svh ====
// Constants for the port overload fault timer: field codes, times, clock rate.
// Assumes a single 50 MHz system clock.
`ifndef POFT_DEFINES_SVH
`define POFT_DEFINES_SVH

// ==========================================
// Clock
`define POFT_CLK_KHZ 50000

// ==========================================
// Overload timeout selection codes and nominal times in ms
`define POFT_SEL_60 2'h0
`define POFT_SEL_30 2'h1
`define POFT_SEL_120 2'h2
`define POFT_SEL_240 2'h3
`define POFT_T_OVLD_60_MS 60
`define POFT_T_OVLD_30_MS 30
`define POFT_T_OVLD_120_MS 120
`define POFT_T_OVLD_240_MS 240

// ==========================================
// Fault cooldown time in ms
`define POFT_T_COOL_MS 1000

// ==========================================
// Channel operating modes, two bits per channel
`define POFT_MODE_OFF 2'h0
`define POFT_MODE_MANUAL 2'h1
`define POFT_MODE_SEMIAUTO 2'h2
`define POFT_MODE_AUTO 2'h3

// ==========================================
// Widths and counts
`define POFT_NCH 8
`define POFT_CNT_W 24
`define POFT_COOL_W 26
`define POFT_PRE_W 4
`define POFT_PRE_LAST 4'hf

`endif

// ==== inc/poft_pkg.sv ====
// Types shared by the port overload fault timer.
// Assumes poft_defines.svh is on the include path.
`include "poft_defines.svh"

package poft_pkg;
  // Cooldown state of one channel
  typedef enum logic {COOL_IDLE, COOL_RUN} poft_cool_e;
  typedef logic [`POFT_CNT_W-1:0] poft_cnt_t;
  typedef logic [`POFT_COOL_W-1:0] poft_cool_t;
endpackage : poft_pkg

// ==== logic/poft_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to CLK.
`timescale 1ns/1ps
`include "poft_defines.svh"

module poft_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Accept a bit once stages two and three agree
  always_comb
  begin
    out_next = out_reg;
    for (int i = 0; i < W; i++)
    begin
      if (s2_reg[i] == s3_reg[i])
      begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  // Shift chain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule : poft_sync

// ==== logic/poft_timer.sv ====
// Eight-channel overload fault timer with cooldown and semiauto redetect.
// Assumes host configuration bits and channel events are synchronous to CLK;
// current sense comparator outputs arrive asynchronously and are synchronised.
`timescale 1ns/1ps
`include "poft_defines.svh"

module poft_timer #(
  parameter int CYC_30 = `POFT_T_OVLD_30_MS * `POFT_CLK_KHZ,
  parameter int CYC_60 = `POFT_T_OVLD_60_MS * `POFT_CLK_KHZ,
  parameter int CYC_120 = `POFT_T_OVLD_120_MS * `POFT_CLK_KHZ,
  parameter int CYC_240 = `POFT_T_OVLD_240_MS * `POFT_CLK_KHZ,
  parameter int CYC_COOL = `POFT_T_COOL_MS * `POFT_CLK_KHZ
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [`POFT_NCH-1:0] POWER_CUT_SENSE,
  input wire logic [`POFT_NCH-1:0] PORT_CURRENT_LIMIT,
  input wire logic [1:0] OVERLOAD_TIME_SELECT,
  input wire logic [`POFT_NCH-1:0] OVERLOAD_CUT_DISABLE,
  input wire logic [`POFT_NCH-1:0] CHAN_ENABLE,
  input wire logic [`POFT_NCH-1:0] CHAN_RESET_CMD,
  input wire logic [`POFT_NCH-1:0] DC_DISCONNECT,
  input wire logic [`POFT_NCH-1:0] PORT_ON,
  input wire logic [2*`POFT_NCH-1:0] CHAN_MODE,
  input wire logic [`POFT_NCH-1:0] DETECT_ENABLE,
  output logic [`POFT_NCH-1:0] TURN_OFF,
  output logic [`POFT_NCH-1:0] OVERLOAD_TIMEOUT,
  output logic [`POFT_NCH-1:0] DETECT_RESTART,
  output logic [`POFT_NCH-1:0] TIMER_ACTIVE,
  output logic [`POFT_NCH-1:0] COOLDOWN_BUSY
);
  localparam int NCH = `POFT_NCH;

  logic [NCH-1:0] cut_sync;
  logic [NCH-1:0] lim_sync;
  poft_pkg::poft_cnt_t cnt_reg [NCH];
  poft_pkg::poft_cnt_t cnt_next [NCH];
  poft_pkg::poft_cool_t cool_reg [NCH];
  poft_pkg::poft_cool_t cool_next [NCH];
  poft_pkg::poft_cool_e cst_reg [NCH];
  poft_pkg::poft_cool_e cst_next [NCH];
  logic [`POFT_PRE_W-1:0] pre_reg;
  logic [`POFT_PRE_W-1:0] pre_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [NCH-1:0] dcut_reg;
  logic [NCH-1:0] dcut_next;
  logic [NCH-1:0] off_reg;
  logic [NCH-1:0] off_next;
  logic [NCH-1:0] tmo_reg;
  logic [NCH-1:0] tmo_next;
  logic [NCH-1:0] det_reg;
  logic [NCH-1:0] det_next;
  logic [NCH-1:0] act_reg;
  logic [NCH-1:0] act_next;
  logic [NCH-1:0] busy_reg;
  logic [NCH-1:0] busy_next;

  // ==========================================
  // Timeout lookup
  function automatic poft_pkg::poft_cnt_t sel_limit(input logic [1:0] sel);
    poft_pkg::poft_cnt_t lim;
    case (sel)
      `POFT_SEL_60: lim = poft_pkg::poft_cnt_t'(CYC_60);
      `POFT_SEL_30: lim = poft_pkg::poft_cnt_t'(CYC_30);
      `POFT_SEL_120: lim = poft_pkg::poft_cnt_t'(CYC_120);
      `POFT_SEL_240: lim = poft_pkg::poft_cnt_t'(CYC_240);
      default: lim = poft_pkg::poft_cnt_t'(CYC_60);
    endcase
    return lim;
  endfunction : sel_limit

  // ==========================================
  // Sense synchronisers
  poft_sync #(.W(2*NCH)) u_sync (
    .clk(CLK),
    .nrst(NRST),
    .din({PORT_CURRENT_LIMIT, POWER_CUT_SENSE}),
    .dout({lim_sync, cut_sync})
  );

  // ==========================================
  // Overload counters and timeout events
  always_comb
  begin
    poft_pkg::poft_cnt_t lim;
    logic sel_chg;
    logic over;
    logic clr;
    lim = sel_limit(OVERLOAD_TIME_SELECT);
    sel_chg = (OVERLOAD_TIME_SELECT != sel_reg);
    over = 1'b0;
    clr = 1'b0;
    pre_next = pre_reg + 4'h1; // Shared one-in-sixteen prescaler
    sel_next = OVERLOAD_TIME_SELECT;
    dcut_next = OVERLOAD_CUT_DISABLE;
    off_next = '0;
    tmo_next = '0;
    act_next = '0;
    for (int i = 0; i < NCH; i++)
    begin
      cnt_next[i] = cnt_reg[i];
      over = cut_sync[i] | lim_sync[i];
      clr = CHAN_ENABLE[i] | CHAN_RESET_CMD[i] | DC_DISCONNECT[i] | !PORT_ON[i];
      if (clr)
      begin
        cnt_next[i] = '0;
      end
      else if (sel_chg && cnt_reg[i] != '0)
      begin
        cnt_next[i] = '0;
      end
      else if (dcut_reg[i] != OVERLOAD_CUT_DISABLE[i])
      begin
        cnt_next[i] = '0;
      end
      else if (over)
      begin
        if (cnt_reg[i] + 24'h1 >= lim)
        begin
          cnt_next[i] = lim; // Hold at timeout while overload stays
          if (cnt_reg[i] < lim)
          begin
            tmo_next[i] = 1'b1;
            off_next[i] = !OVERLOAD_CUT_DISABLE[i];
          end
        end
        else
        begin
          cnt_next[i] = cnt_reg[i] + 24'h1;
        end
      end
      else if (pre_reg == `POFT_PRE_LAST && cnt_reg[i] != '0)
      begin
        cnt_next[i] = cnt_reg[i] - 24'h1;
      end
      act_next[i] = (cnt_next[i] != '0);
    end
  end

  // ==========================================
  // Cooldown machines and redetect
  always_comb
  begin
    logic [1:0] mode;
    logic cancel;
    mode = `POFT_MODE_OFF;
    cancel = 1'b0;
    det_next = '0;
    busy_next = '0;
    for (int i = 0; i < NCH; i++)
    begin
      cst_next[i] = cst_reg[i];
      cool_next[i] = cool_reg[i];
      mode = CHAN_MODE[2*i +: 2];
      cancel = CHAN_RESET_CMD[i] | (mode == `POFT_MODE_OFF) | (mode == `POFT_MODE_MANUAL);
      case (cst_reg[i])
        poft_pkg::COOL_IDLE:
        begin
          if (off_reg[i] && !cancel)
          begin
            cst_next[i] = poft_pkg::COOL_RUN;
            cool_next[i] = '0;
          end
        end
        poft_pkg::COOL_RUN:
        begin
          if (cancel)
          begin
            cst_next[i] = poft_pkg::COOL_IDLE;
            cool_next[i] = '0;
          end
          else if (cool_reg[i] >= poft_pkg::poft_cool_t'(CYC_COOL - 1))
          begin
            cst_next[i] = poft_pkg::COOL_IDLE;
            cool_next[i] = '0;
            det_next[i] = (mode == `POFT_MODE_SEMIAUTO) && DETECT_ENABLE[i];
          end
          else
          begin
            cool_next[i] = cool_reg[i] + 26'h1;
          end
        end
        default:
        begin
          cst_next[i] = poft_pkg::COOL_IDLE;
          cool_next[i] = '0;
        end
      endcase
      busy_next[i] = (cst_next[i] == poft_pkg::COOL_RUN);
    end
  end

  // ==========================================
  // State registers
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pre_reg <= '0;
      sel_reg <= `POFT_SEL_60;
      dcut_reg <= '0;
      off_reg <= '0;
      tmo_reg <= '0;
      det_reg <= '0;
      act_reg <= '0;
      busy_reg <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        cnt_reg[i] <= '0;
        cool_reg[i] <= '0;
        cst_reg[i] <= poft_pkg::COOL_IDLE;
      end
    end
    else
    begin
      pre_reg <= pre_next;
      sel_reg <= sel_next;
      dcut_reg <= dcut_next;
      off_reg <= off_next;
      tmo_reg <= tmo_next;
      det_reg <= det_next;
      act_reg <= act_next;
      busy_reg <= busy_next;
      for (int i = 0; i < NCH; i++)
      begin
        cnt_reg[i] <= cnt_next[i];
        cool_reg[i] <= cool_next[i];
        cst_reg[i] <= cst_next[i];
      end
    end
  end

  // Outputs straight from flops
  assign TURN_OFF = off_reg;
  assign OVERLOAD_TIMEOUT = tmo_reg;
  assign DETECT_RESTART = det_reg;
  assign TIMER_ACTIVE = act_reg;
  assign COOLDOWN_BUSY = busy_reg;
endmodule : poft_timer

// ==== testbench/poft_host.sv ====
// Host model holding the timeout select and cut-disable settings.
// Settings change only at the falling clock edge.
`timescale 1ns/1ps
module poft_host (
  input wire logic CLK,
  output logic [1:0] OVERLOAD_TIME_SELECT,
  output logic [7:0] OVERLOAD_CUT_DISABLE
);
  // Settings at time zero
  initial
  begin
    OVERLOAD_TIME_SELECT = 2'h0;
    OVERLOAD_CUT_DISABLE = 8'h00;
  end
  // Configuration write, off the sampling edge
  task automatic write_cfg(input logic [1:0] sel, input logic dis);
    @(negedge CLK);
    OVERLOAD_TIME_SELECT = sel;
    OVERLOAD_CUT_DISABLE = {7'h00, dis};
  endtask : write_cfg
endmodule : poft_host

// ==== testbench/poft_timer_asserts.sv ====
// Checker on poft_timer ports, channel 0 and whole vectors.
// Bound from the testbench top; one clock domain.
`timescale 1ns/1ps
module poft_timer_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [1:0] OVERLOAD_TIME_SELECT,
  input wire logic [7:0] OVERLOAD_CUT_DISABLE,
  input wire logic [7:0] CHAN_ENABLE,
  input wire logic [7:0] CHAN_RESET_CMD,
  input wire logic [7:0] DC_DISCONNECT,
  input wire logic [7:0] PORT_ON,
  input wire logic [15:0] CHAN_MODE,
  input wire logic [7:0] TURN_OFF,
  input wire logic [7:0] OVERLOAD_TIMEOUT,
  input wire logic [7:0] DETECT_RESTART,
  input wire logic [7:0] TIMER_ACTIVE,
  input wire logic [7:0] COOLDOWN_BUSY
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // ==========
  // Cut step, then cooldown kept
  sequence s_cut;
    TURN_OFF[0] && CHAN_MODE[1:0] == 2'h2 && !CHAN_RESET_CMD[0];
  endsequence
  sequence s_keep;
    CHAN_MODE[1:0] == 2'h2 && !CHAN_RESET_CMD[0];
  endsequence
  // ==========
  // Timeout, cooldown and clear relations
  a_cut_disabled: assert property (
    (TURN_OFF & $past(OVERLOAD_CUT_DISABLE)) == 8'h00) else $error("cut while disabled");
  a_timeout_counted: assert property (
    (OVERLOAD_TIMEOUT & ~$past(TIMER_ACTIVE)) == 8'h00) else $error("timeout, no count");
  a_cool_starts: assert property (
    s_cut ##1 s_keep |=> COOLDOWN_BUSY[0]) else $error("no cooldown");
  a_restart_cause: assert property (
    DETECT_RESTART[0] |-> $fell(COOLDOWN_BUSY[0]) && $past(CHAN_MODE[1:0]) == 2'h2)
    else $error("stray restart");
  a_cool_cancel: assert property (
    COOLDOWN_BUSY[0] && (CHAN_RESET_CMD[0] || !CHAN_MODE[1]) |-> ##[1:2] !COOLDOWN_BUSY[0])
    else $error("cooldown kept");
  a_clear_count: assert property (
    CHAN_ENABLE[0] || CHAN_RESET_CMD[0] || DC_DISCONNECT[0] || !PORT_ON[0]
    |=> !TIMER_ACTIVE[0]) else $error("count kept");
  a_sel_restart: assert property (
    $changed(OVERLOAD_TIME_SELECT) && TIMER_ACTIVE[0] |-> ##[1:4] !TIMER_ACTIVE[0])
    else $error("no restart on select");
  a_dis_restart: assert property (
    $changed(OVERLOAD_CUT_DISABLE[0]) && TIMER_ACTIVE[0] |-> ##[1:3] !TIMER_ACTIVE[0])
    else $error("no restart on disable");
endmodule : poft_timer_chk

// ==== testbench/poft_timer_tb_top.sv ====
// Testbench for poft_timer: timeout table, cooldown, decay, clears.
// Channel 0 carries the traffic; short cycle counts set by parameter.
`timescale 1ns/1ps
module poft_timer_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] cut = 8'h00, lim = 8'h00, ena = 8'h00, rst = 8'h00, dcd = 8'h00;
  logic [7:0] pon = 8'h01, den = 8'h01, dis, toff, tout, drst, tact, cbusy;
  logic [15:0] mode = 16'h0002;
  logic [1:0] sel;
  int num_errors = 0, checks = 0, n;
  int rows[5][3] = '{'{0, 40, 0}, '{1, 20, 0}, '{2, 80, 0}, '{3, 160, 0}, '{1, 20, 1}};
  poft_host poft_host_inst (.CLK(clk), .OVERLOAD_TIME_SELECT(sel), .OVERLOAD_CUT_DISABLE(dis));
  poft_timer #(.CYC_30(20), .CYC_60(40), .CYC_120(80), .CYC_240(160), .CYC_COOL(50))
  poft_timer_inst (.CLK(clk), .NRST(nrst), .POWER_CUT_SENSE(cut), .PORT_CURRENT_LIMIT(lim),
    .OVERLOAD_TIME_SELECT(sel), .OVERLOAD_CUT_DISABLE(dis), .CHAN_ENABLE(ena),
    .CHAN_RESET_CMD(rst), .DC_DISCONNECT(dcd), .PORT_ON(pon), .CHAN_MODE(mode),
    .DETECT_ENABLE(den), .TURN_OFF(toff), .OVERLOAD_TIMEOUT(tout),
    .DETECT_RESTART(drst), .TIMER_ACTIVE(tact), .COOLDOWN_BUSY(cbusy));
  // Clock, 20 ns period
  initial forever #10 clk = ~clk;
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  // Count falling edges until bit 0 reaches a level
  task automatic wait_bit(ref logic [7:0] v, input logic lvl, output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (v[0] !== lvl && k < 400);
  endtask : wait_bit
  // Verdict and end of run
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk("outputs after reset", 0, |{toff, tout, drst, tact, cbusy});
    foreach (rows[i])
    begin
      poft_host_inst.write_cfg(rows[i][0][1:0], rows[i][2][0]);
      {lim[0], cut[0]} = (i == 3) ? 2'h2 : 2'h1;
      wait_bit(tout, 1'b1, n);
      // Four edges through the sense synchroniser, then one count per edge
      chk("cycles to timeout", rows[i][1] + 4, n);
      chk("turn off", !rows[i][2][0], toff[0]);
      {lim[0], cut[0]} = 2'h0;
      pon[0] = rows[i][2][0];
      if (rows[i][2] == 0)
      begin
        wait_bit(drst, 1'b1, n);
        chk("cooldown cycles", 51, n);
      end
      {ena[0], pon[0]} = 2'h3;
      @(negedge clk);
      ena[0] = 1'b0;
    end
    // Select change while counting
    poft_host_inst.write_cfg(2'h0, 1'b0);
    cut[0] = 1'b1;
    repeat (15) @(negedge clk);
    poft_host_inst.write_cfg(2'h1, 1'b0);
    wait_bit(tout, 1'b1, n);
    chk("select restart", 1, n >= 21 && n <= 22);
    // Cooldown cancelled by reset command
    {cut[0], pon[0]} = 2'h0;
    repeat (10) @(negedge clk);
    chk("cooldown before cancel", 1, cbusy[0]);
    rst[0] = 1'b1;
    @(negedge clk);
    chk("cooldown after cancel", 0, cbusy[0]);
    rst[0] = 1'b0;
    wait_bit(drst, 1'b1, n);
    chk("restart after cancel", 400, n);
    // Disconnect clear, then slow decay
    {cut[0], pon[0]} = 2'h3;
    repeat (10) @(negedge clk);
    dcd[0] = 1'b1;
    @(negedge clk);
    chk("cleared by disconnect", 0, tact[0]);
    dcd[0] = 1'b0;
    @(negedge clk);
    cut[0] = 1'b0;
    pon[0] = 1'b0;
    repeat (6) @(negedge clk);
    {cut[0], pon[0]} = 2'h3;
    repeat (10) @(negedge clk);
    cut[0] = 1'b0;
    wait_bit(tact, 1'b0, n);
    chk("decay cycles", 1, n >= 140 && n <= 180);
    // Cooldown without detect enable ends with no restart
    den[0] = 1'b0;
    {cut[0], pon[0]} = 2'h3;
    wait_bit(tout, 1'b1, n);
    chk("timeout for cooldown", 24, n);
    {cut[0], pon[0]} = 2'h0;
    wait_bit(cbusy, 1'b0, n);
    chk("cooldown length", 51, n);
    chk("restart without enable", 0, drst[0]);
    // Manual mode abandons a running cooldown
    den[0] = 1'b1;
    {cut[0], pon[0]} = 2'h3;
    wait_bit(tout, 1'b1, n);
    {cut[0], pon[0]} = 2'h0;
    @(negedge clk);
    chk("cooldown running", 1, cbusy[0]);
    mode[1:0] = 2'h1;
    @(negedge clk);
    chk("cooldown abandoned", 0, cbusy[0]);
    mode[1:0] = 2'h2;
    repeat (4) @(negedge clk);
    chk("no restart after manual", 0, drst[0]);
    give_verdict();
  end
  // Watchdog
  initial
  begin
    #(20 * 6000);
    num_errors++;
    give_verdict();
  end
endmodule : poft_timer_tb_top
bind poft_timer poft_timer_chk poft_timer_chk_inst (.CLK, .NRST, .OVERLOAD_TIME_SELECT,
  .OVERLOAD_CUT_DISABLE, .CHAN_ENABLE, .CHAN_RESET_CMD, .DC_DISCONNECT, .PORT_ON,
  .CHAN_MODE, .TURN_OFF, .OVERLOAD_TIMEOUT, .DETECT_RESTART, .TIMER_ACTIVE, .COOLDOWN_BUSY);
